// File: hdl/cie_alu.sv
// Combinational result unit: increment, decrement, OR and zero detect.
// Assumes operands are stable within one clock cycle.
`timescale 1ns/1ps
`default_nettype none
module cie_alu (
   // Operands
   input  wire logic [7:0] opa_i,
   input  wire logic [7:0] lit_i,
   // Results
   output logic      [7:0] inc_o,
   output logic      [7:0] dec_o,
   output logic      [7:0] or_o,
   output logic            inc_zero_o,
   output logic            dec_zero_o,
   output logic            or_zero_o
);
   // ****************************************************
   // Arithmetic
   // ****************************************************
   // Wraps modulo 256 on purpose
   always_comb begin
      inc_o      = opa_i + 8'h01;
      dec_o      = opa_i - 8'h01;
      or_o       = opa_i | lit_i;
      inc_zero_o = (inc_o == 8'h00);
      dec_zero_o = (dec_o == 8'h00);
      or_zero_o  = (or_o == 8'h00);
   end
endmodule // cie_alu
`default_nettype wire

// File: hdl/cie_core.sv
// Top of the instruction execution subset: decode, accumulator, flag, PC.
// Assumes the file space answers file_rdata_i combinationally for file_addr_o.
`timescale 1ns/1ps
`default_nettype none
module cie_core
   import cie_pkg::*;
(
   // Clock and reset
   input  wire logic                ref_clk_i,
   input  wire logic                sys_rst_i,
   // Instruction fetch
   input  wire logic [CIE_IW-1:0]   instr_i,
   input  wire logic [CIE_DW-1:0]   upper_pc_latch_i,
   output logic      [CIE_PW-1:0]   pc_o,
   // File register space
   output logic      [CIE_AW-1:0]   file_addr_o,
   input  wire logic [CIE_DW-1:0]   file_rdata_i,
   output logic      [CIE_DW-1:0]   file_wdata_o,
   output logic                     file_we_o,
   // State
   output logic      [CIE_DW-1:0]   acc_o,
   output logic                     result_null_flag_o,
   output logic                     flush_o
);
   import cie_pkg::*;

   // ****************************************************
   // State
   // ****************************************************
   logic [CIE_PW-1:0] pc_reg, pc_next;          // Program counter
   logic [CIE_DW-1:0] acc_reg, acc_next;        // Accumulator
   logic              zf_reg, zf_next;          // Result null flag
   logic              fl_reg, fl_next;          // Next word becomes a no-operation
   logic [CIE_DW-1:0] fw_reg, fw_next;          // File write data out
   logic              we_reg, we_next;          // File write strobe

   // ****************************************************
   // Result unit
   // ****************************************************
   logic [CIE_DW-1:0] inc_v, dec_v, or_v;       // Candidate results
   logic              inc_z, dec_z, or_z;       // Zero detect per result

   // Accumulator OR uses the literal; file ops use the file read data
   cie_alu u_alu (
      .opa_i      (instr_i[13:8] == CIE_OP_ORLIT ? acc_reg : file_rdata_i),
      .lit_i      (instr_i[7:0]),
      .inc_o      (inc_v),
      .dec_o      (dec_v),
      .or_o       (or_v),
      .inc_zero_o (inc_z),
      .dec_zero_o (dec_z),
      .or_zero_o  (or_z)
   );

   // Address is decoded straight from the word so reads see it this cycle
   assign file_addr_o = instr_i[CIE_AW-1:0];

   logic dest_file;                             // Destination bit
   assign dest_file = instr_i[CIE_DEST_BIT];

   // ****************************************************
   // Decode and execute
   // ****************************************************
   // A flushed cycle always executes as a no-operation: this is how skips
   // and jumps spend their second cycle without a separate state machine.
   always_comb begin
      pc_next  = pc_reg + 13'h0001;
      acc_next = acc_reg;
      zf_next  = zf_reg;
      fl_next  = 1'b0;
      fw_next  = fw_reg;
      we_next  = 1'b0;
      if (!fl_reg) begin
         if (instr_i[13:7] == CIE_OP_CLRACC) begin
            acc_next = 8'h00;                                   // RULE1
            zf_next  = 1'b1;                                    // RULE1
         end else if (instr_i[13:11] == CIE_OP_JUMP) begin
            pc_next = {upper_pc_latch_i[CIE_LATCH_LO+1:CIE_LATCH_LO],
                       instr_i[10:0]};                          // RULE6
            fl_next = 1'b1;                                     // RULE7
         end else begin
            case (instr_i[13:8])
               CIE_OP_DECSKP: begin
                  if (dest_file) begin
                     fw_next = dec_v;                           // RULE2
                     we_next = 1'b1;                            // RULE2
                  end else begin
                     acc_next = dec_v;                          // RULE2
                  end
                  fl_next = dec_z;                              // RULE3
               end
               CIE_OP_INCSKP: begin
                  if (dest_file) begin
                     fw_next = inc_v;                           // RULE4
                     we_next = 1'b1;                            // RULE4
                  end else begin
                     acc_next = inc_v;                          // RULE4
                  end
                  fl_next = inc_z;                              // RULE5
               end
               CIE_OP_INCREMENT_FILE: begin
                  if (dest_file) begin
                     fw_next = inc_v;                           // RULE9
                     we_next = 1'b1;                            // RULE9
                  end else begin
                     acc_next = inc_v;                          // RULE9
                  end
                  zf_next = inc_z;                              // RULE10
               end
               CIE_OP_ORLIT: begin
                  acc_next = or_v;                              // RULE8
                  zf_next  = or_z;                              // RULE10
               end
               default: begin
                  // Words outside this subset act as a no-operation
                  zf_next = zf_reg;
               end
            endcase
         end
      end
   end

   // ****************************************************
   // Registers
   // ****************************************************
   // Synchronous reset only; every register loads each edge
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         pc_reg  <= CIE_PC_RST;
         acc_reg <= CIE_ACC_RST;
         zf_reg  <= 1'b0;
         fl_reg  <= 1'b0;
         fw_reg  <= 8'h00;
         we_reg  <= 1'b0;
      end else begin
         pc_reg  <= pc_next;
         acc_reg <= acc_next;
         zf_reg  <= zf_next;
         fl_reg  <= fl_next;
         fw_reg  <= fw_next;
         we_reg  <= we_next;
      end
   end

   // ****************************************************
   // Outputs
   // ****************************************************
   assign pc_o               = pc_reg;
   assign acc_o              = acc_reg;
   assign result_null_flag_o = zf_reg;
   assign flush_o            = fl_reg;
   assign file_wdata_o       = fw_reg;
   assign file_we_o          = we_reg;
endmodule // cie_core
`default_nettype wire

// File: hdl/cie_pkg.sv
// Constants, opcode fields and reset values for the instruction execution subset.
// Assumes 14-bit instruction words and an 8-bit data path.
// Behaviour
// RULE1: Clear accumulator loads zero, sets null flag.
// RULE2: Decrement file, result to accumulator or file.
// RULE3: Zero decrement result skips next as no-operation.
// RULE4: Increment-skip writes per destination, flags unchanged.
// RULE5: Zero increment result skips next as no-operation.
// RULE6: Jump loads literal and latch bits 4:3.
// RULE7: Jump always branches, two cycles, no flags.
// RULE8: OR literal into accumulator, update null flag.
// RULE9: Increment file per destination, update null flag.
// RULE10: Null flag set on zero result, else cleared.
package cie_pkg;
   // ****************************************************
   // Widths
   // ****************************************************
   localparam int CIE_IW = 14;                          // Instruction word width
   localparam int CIE_DW = 8;                           // Data width
   localparam int CIE_PW = 13;                          // Program counter width
   localparam int CIE_AW = 7;                           // File address width
   // ****************************************************
   // Opcode patterns (upper bits of the word)
   // ****************************************************
   localparam logic [6:0] CIE_OP_CLRACC = 7'h02;        // Word[13:7]
   localparam logic [5:0] CIE_OP_DECSKP = 6'h0b;        // Word[13:8]
   localparam logic [5:0] CIE_OP_INCSKP = 6'h0f;        // Word[13:8]
   localparam logic [5:0] CIE_OP_INCREMENT_FILE   = 6'h0a;        // Word[13:8]
   localparam logic [5:0] CIE_OP_ORLIT  = 6'h38;        // Word[13:8]
   localparam logic [2:0] CIE_OP_JUMP   = 3'h5;         // Word[13:11]
   // ****************************************************
   // Field positions
   // ****************************************************
   localparam int CIE_DEST_BIT = 7;                     // Destination bit
   localparam int CIE_LATCH_LO = 3;                     // Upper latch bit used for PC[11]
   // ****************************************************
   // Reset values
   // ****************************************************
   localparam logic [12:0] CIE_PC_RST  = 13'h0000;      // Program counter after reset
   localparam logic [7:0]  CIE_ACC_RST = 8'h00;         // Accumulator after reset
endpackage

// File: sim/cie_chk.sv
// Checker for the instruction subset, bound to cie_core.
// Assumes one clock and a synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module cie_chk
   import cie_pkg::*;
(
   input wire logic        ref_clk_i, sys_rst_i, file_we_o, result_null_flag_o, flush_o,
   input wire logic [13:0] instr_i,
   input wire logic [12:0] pc_o,
   input wire logic [7:0]  upper_pc_latch_i, file_rdata_i, file_wdata_o, acc_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   logic        go, sk_w, or_w;  // Live word, skip word, literal word
   logic [7:0]  sk_res, or_res;  // Expected results
   logic [12:0] tgt;             // Expected jump target
   assign go = !flush_o;
   assign sk_w = go && (instr_i[13:8] == CIE_OP_DECSKP || instr_i[13:8] == CIE_OP_INCSKP);
   // Bit 10 tells the increment form from the decrement form
   assign sk_res = instr_i[10] ? file_rdata_i + 8'h01 : file_rdata_i - 8'h01;
   assign or_w = go && instr_i[13:8] == CIE_OP_ORLIT;
   assign or_res = acc_o | instr_i[7:0];
   assign tgt = {upper_pc_latch_i[4:3], instr_i[10:0]};
   sequence s_jump; go && instr_i[13:11] == CIE_OP_JUMP; endsequence
   sequence s_two; flush_o ##1 !flush_o; endsequence
   a_clear_acc: assert property (go && instr_i[13:7] == CIE_OP_CLRACC
      |=> acc_o == 8'h00 && result_null_flag_o) else $error("clear gave wrong state");
   a_skip_taken: assert property (sk_w
      |=> flush_o == ($past(sk_res) == 8'h00)) else $error("skip decision wrong");
   a_skip_acc: assert property (sk_w && !instr_i[7]
      |=> acc_o == $past(sk_res) && $stable(result_null_flag_o)) else $error("skip acc wrong");
   a_skip_file: assert property (sk_w && instr_i[7]
      |=> file_we_o && file_wdata_o == $past(sk_res)) else $error("skip write wrong");
   a_jump_pc: assert property (s_jump |=> pc_o == $past(tgt))
      else $error("jump target wrong");
   a_jump_cycles: assert property (s_jump |=> s_two)
      else $error("jump not two cycles");
   a_or_lit: assert property (or_w |=> acc_o == $past(or_res)
      && result_null_flag_o == (acc_o == 8'h00)) else $error("or result wrong");
   a_increment_file_flag: assert property (go && instr_i[13:8] == CIE_OP_INCREMENT_FILE
      |=> result_null_flag_o == ($past(file_rdata_i) == 8'hff)) else $error("increment_file flag wrong");
endmodule // cie_chk
`default_nettype wire

// File: sim/cie_core_tb.sv
// Bench for cie_core: one word per cycle, checks state, pc and writes.
// Assumes the cie_fmem partner and the cie_chk checker bound below.
`timescale 1ns/1ps
`default_nettype none
module cie_core_tb;
   import cie_pkg::*;
   logic        ref_clk_i = 1'b0, sys_rst_i = 1'b1;
   logic [13:0] instr_i = 14'h0000;           // Word under execution
   logic [7:0]  latch = 8'h00, rdata, wdata, acc;
   logic [12:0] pc, pc_exp = 13'h0000;        // Expected program counter
   logic [6:0]  faddr;
   logic        we, flag, flush;
   int          error_cnt = 0, compares = 0;
   always #10 ref_clk_i = ~ref_clk_i;
   cie_core cie_core_inst (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .instr_i(instr_i),
      .upper_pc_latch_i(latch), .pc_o(pc), .file_addr_o(faddr), .file_rdata_i(rdata),
      .file_wdata_o(wdata), .file_we_o(we), .acc_o(acc), .result_null_flag_o(flag),
      .flush_o(flush));
   cie_fmem cie_fmem_inst (.clk_i(ref_clk_i), .addr_i(faddr), .wdata_i(wdata), .we_i(we),
      .rdata_o(rdata));
   // Wide enough for the widest packed compare (flag, acc and a file word)
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   // A jump reloads the pc, any other word (even a discarded one) steps it
   task run(input logic [13:0] w);
      instr_i <= w;
      @(posedge ref_clk_i);
      #1;
      pc_exp = (w[13:11] == CIE_OP_JUMP) ? {latch[4:3], w[10:0]} : pc_exp + 13'h0001;
      chk(pc, pc_exp);
   endtask
   task t_arith;
      run({CIE_OP_INCREMENT_FILE, 1'b0, 7'h06});
      chk({flag, acc}, 9'h002);
      run(14'h0100);
      chk({flag, acc}, 9'h100);
      run({CIE_OP_ORLIT, 8'h00});
      chk({flag, acc}, 9'h100);
      run({CIE_OP_ORLIT, 8'h81});
      chk({flag, acc}, 9'h081);
      run({CIE_OP_INCREMENT_FILE, 1'b1, 7'h07});
      chk({we, wdata}, 9'h111);
   endtask
   // Discarded words are chosen so that executing them would show
   task t_skip;
      run({CIE_OP_INCSKP, 1'b1, 7'h05});
      chk({flush, flag, acc}, 10'h281);
      run(14'h0100);
      chk({flag, acc, cie_fmem_inst.mem[5]}, 17'h08100);
      run({CIE_OP_DECSKP, 1'b0, 7'h06});
      chk({flush, flag, acc}, 10'h200);
      run({CIE_OP_ORLIT, 8'hff});
      chk({flush, acc}, 9'h000);
      run({CIE_OP_DECSKP, 1'b0, 7'h07});
      chk({flush, acc}, 9'h010);
      run({CIE_OP_INCSKP, 1'b0, 7'h07});
      chk({flush, acc}, 9'h012);
      run({CIE_OP_DECSKP, 1'b1, 7'h07});
      chk({flush, we, wdata}, 10'h110);
   endtask
   task t_jump;
      latch <= 8'h08;
      run({CIE_OP_JUMP, 11'h555});
      chk({flush, pc}, 14'h2d55);
      run(14'h0100);
      chk({flush, flag, acc}, 10'h012);
      latch <= 8'h10;
      run({CIE_OP_JUMP, 11'h7ff});
      run(14'h0000);
      chk(flush, 1'b0);
   endtask
   task summarize;
      $display("Compares %0d, mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      cie_fmem_inst.mem[5] = 8'hff;
      cie_fmem_inst.mem[6] = 8'h01;
      cie_fmem_inst.mem[7] = 8'h10;
      repeat (6) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      t_arith;
      t_skip;
      t_jump;
      summarize;
   end
   // About 22 cycles are needed; 300 cycles, over thirteen times that, means a hang
   initial begin
      #6000;
      error_cnt++;
      summarize;
   end
endmodule // cie_core_tb
bind cie_core cie_chk cie_chk_inst (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
   .file_we_o(file_we_o), .result_null_flag_o(result_null_flag_o), .flush_o(flush_o),
   .instr_i(instr_i), .pc_o(pc_o), .upper_pc_latch_i(upper_pc_latch_i),
   .file_rdata_i(file_rdata_i), .file_wdata_o(file_wdata_o), .acc_o(acc_o));
`default_nettype wire

// File: sim/cie_fmem.sv
// Partner: file register space, 128 x 8, read without delay.
// Assumes the write pulse comes one cycle after the word naming the address.
`timescale 1ns/1ps
`default_nettype none
module cie_fmem (
   input  wire logic       clk_i,
   input  wire logic [6:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       we_i,
   output logic      [7:0] rdata_o
);
   logic [7:0] mem [128];  // Storage, preloaded by the bench
   logic [6:0] wa_q;       // Address of the word one cycle back
   assign rdata_o = mem[addr_i];
   // Write lands late, so the previous address is kept
   always @(posedge clk_i) begin
      wa_q <= addr_i;
      if (we_i) mem[wa_q] <= wdata_i;
   end
endmodule // cie_fmem
`default_nettype wire
